// >>> fmcsb_pkg.sv
// Constants for the fan monitor configuration and status register bank
package fmcsb_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DIODE2_IDEALITY = 8'h3B;
  localparam logic [7:0] ADDR_DIODE3_IDEALITY = 8'h3C;
  localparam logic [7:0] ADDR_PWM_OUTPUT_CFG  = 8'h3D;
  localparam logic [7:0] ADDR_MAKER_CODE      = 8'h3E;
  localparam logic [7:0] ADDR_DIE_REVISION    = 8'h3F;
  localparam logic [7:0] ADDR_LOCK_AND_START  = 8'h40;
  localparam logic [7:0] ADDR_ALERT_FLAGS_1   = 8'h41;
  localparam logic [7:0] ADDR_ALERT_FLAGS_2   = 8'h42;
  localparam logic [7:0] ADDR_ALERT_FLAGS_3   = 8'h44;
  localparam logic [7:0] ADDR_ALERT_FLAGS_4   = 8'h45;

  // Reset values
  localparam logic [5:0] RST_IDEALITY   = 6'h12;
  localparam logic [5:0] RST_PWM_CFG    = 6'h0F;
  localparam logic       RST_START      = 1'b1;
  localparam logic [7:0] RST_ALERT      = 8'h00;

  // Field positions
  localparam int POS_SECOND_PWM_TYPE = 5;
  localparam int POS_FIRST_PWM_TYPE  = 4;
  localparam int POS_SECOND_FREQ     = 2;
  localparam int POS_FIRST_FREQ      = 0;
  localparam int POS_LOCK            = 1;
  localparam int POS_START           = 0;
  localparam int POS_GPIO_CHANGE     = 7;
  localparam int POS_FAN2_SPEED_FAULT_FLAG           = 7;
  localparam int POS_FAN1_SPEED_FAULT_FLAG           = 6;

  // Alert flags 4 bit 5 is reserved
  localparam logic [7:0] ALERT4_USED = 8'hDF;

  // Ideality factor scaled by 10000
  localparam logic [5:0]  IDEAL_CODE_MIN   = 6'h08;
  localparam logic [5:0]  IDEAL_CODE_MAX   = 6'h37;
  localparam logic [13:0] IDEAL_FACTOR_MIN = 14'd9951;
  localparam logic [13:0] IDEAL_STEP_E2    = 14'd1359;
  localparam logic [13:0] IDEAL_STEP_DIV   = 14'd100;

  // PWM base frequency selection
  localparam logic [1:0] FREQ_26K    = 2'b00;
  localparam logic [1:0] FREQ_19K5   = 2'b01;
  localparam logic [1:0] FREQ_4882   = 2'b10;
  localparam logic [1:0] FREQ_2441   = 2'b11;

  localparam int CLK_HZ       = 50_000_000;
  localparam int F26K_HZ      = 26_000;
  localparam int F19K5_HZ     = 19_500;
  localparam int F4882_HZ     = 4_882;
  localparam int F2441_HZ     = 2_441;
  localparam int STEPS_8BIT   = 256;
  localparam int STEPS_10BIT  = 1024;

  // Prescale counts per duty step
  localparam logic [4:0] DIV_26K  = 5'(CLK_HZ / (F26K_HZ * STEPS_8BIT));
  localparam logic [4:0] DIV_19K5 = 5'(CLK_HZ / (F19K5_HZ * STEPS_10BIT));
  localparam logic [4:0] DIV_4882 = 5'(CLK_HZ / (F4882_HZ * STEPS_10BIT));
  localparam logic [4:0] DIV_2441 = 5'(CLK_HZ / (F2441_HZ * STEPS_10BIT));

  localparam logic [9:0] TOP_8BIT  = 10'h0FF;
  localparam logic [9:0] TOP_10BIT = 10'h3FF;

endpackage : fmcsb_pkg

// >>> fmcsb_bank.sv
// Configuration, identity, lock/start and alert status register bank
//
// How it works
// - Two diode ideality registers hold six-bit codes, reset 12h, factor 1.0086.
// - Ideality code maps monotonically to factor, 001000 near 0.9951, 110111 near 1.0589.
// - Config bit 5: second PWM pin open drain (0, reset) or push-pull (1).
// - Config bit 4: first PWM pin open drain (0, reset) or push-pull (1).
// - Bits 3:2 pick second PWM base: 26k, 19.5k, 4882, 2441 Hz default.
// - Bits 1:0 pick first PWM base with the same encoding.
// - PWM duty is 8-bit at the fastest base, 10-bit otherwise.
// - Maker code register returns a fixed byte and ignores the lock.
// - Revision register at 3Fh returns a fixed die revision byte.
// - Lock bit set makes every lockable register read-only.
// - Start bit is read-only and set whenever low power mode is set.
// - Without low power mode, start is one only with both power inputs good.
// - Each status input has its own enable plus one global disable.
// - Interrupt pin driven low when any flag set and global enable is one.
// - Reading a status register clears set bits whose cause has gone.
// - Interrupt pin released once no flag remains set.
// - Flags 1 hold diode2 fault/limit, internal, diode1 limit/fault, supply, inputs 1, 2.
// - Diode 1 limit flag follows only software limits, not voltage threshold.
// - Flags 2 hold io change, shutdown, diode3 fault/limit, regulator, fan shorts.
// - IO change flag clears on read unless an unmasked change arrives in that cycle, and sets only on unmasked changes.
// - Tach flag set on stall, failed spin-up or target unreachable at full drive.
`timescale 1ns/100ps

module fmcsb_bank
  import fmcsb_pkg::*;
#(
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE_VALUE   = 8'hA7,
  parameter logic [7:0] DIE_REVISION_VALUE = 8'h01
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rdata,
  input  wire logic        low_power_mode_bit,
  input  wire logic        power_ok_3v3_input_n,
  input  wire logic        supply_power_good_input,
  input  wire logic        global_interrupt_enable,
  input  wire logic [7:0]  alert_enable_1,
  input  wire logic [7:0]  alert_enable_2,
  input  wire logic [7:0]  alert_enable_3,
  input  wire logic [7:0]  alert_enable_4,
  input  wire logic [7:0]  alert_cond_1,
  input  wire logic [6:0]  alert_cond_2,
  input  wire logic        gpio_change_pulse,
  input  wire logic [7:0]  alert_cond_3,
  input  wire logic [4:0]  alert_cond_4,
  input  wire logic        fan1_stall,
  input  wire logic        fan1_spinup_fail,
  input  wire logic        fan1_drive_fail,
  input  wire logic        fan2_stall,
  input  wire logic        fan2_spinup_fail,
  input  wire logic        fan2_drive_fail,
  input  wire logic [9:0]  fan1_duty,
  input  wire logic [9:0]  fan2_duty,
  output logic             alert_interrupt_pin_n,
  output logic [5:0]       diode2_ideality_code,
  output logic [5:0]       diode3_ideality_code,
  output logic [13:0]      diode2_factor_e4,
  output logic [13:0]      diode3_factor_e4,
  output logic             first_pwm_output_type,
  output logic             second_pwm_output_type,
  output logic [1:0]       first_pwm_freq_select,
  output logic [1:0]       second_pwm_freq_select,
  output logic             first_pwm_pin_out,
  output logic             first_pwm_pin_oe,
  output logic             second_pwm_pin_out,
  output logic             second_pwm_pin_oe,
  output logic             software_lock,
  output logic             start_status
);

  logic [5:0]  diode2_ideality_reg;
  logic [5:0]  diode3_ideality_reg;
  logic [5:0]  pwm_cfg_reg;
  logic        lock_reg;
  logic        start_reg;
  logic [7:0]  alert_reg [4];
  logic [7:0]  cond_level [4];
  logic [7:0]  set_now [4];
  logic [7:0]  enable_in [4];
  logic [7:0]  read_keep [4];
  logic [3:0]  rd_hit;
  logic        wr_ok;
  logic        any_flag;
  logic [7:0]  rdata_next;
  logic        fan1_speed_fault_flag_cause;
  logic        fan2_speed_fault_flag_cause;

  assign wr_ok = reg_wr_en && !lock_reg;

  assign fan1_speed_fault_flag_cause = fan1_stall | fan1_spinup_fail | fan1_drive_fail;
  assign fan2_speed_fault_flag_cause = fan2_stall | fan2_spinup_fail | fan2_drive_fail;

  assign cond_level[0] = alert_cond_1;
  assign cond_level[1] = {1'b0, alert_cond_2};
  assign cond_level[2] = alert_cond_3;
  assign cond_level[3] = {fan2_speed_fault_flag_cause, fan1_speed_fault_flag_cause, 1'b0, alert_cond_4};

  assign enable_in[0] = alert_enable_1;
  assign enable_in[1] = alert_enable_2;
  assign enable_in[2] = alert_enable_3;
  assign enable_in[3] = alert_enable_4;

  assign rd_hit[0] = reg_rd_en && (reg_addr == ADDR_ALERT_FLAGS_1);
  assign rd_hit[1] = reg_rd_en && (reg_addr == ADDR_ALERT_FLAGS_2);
  assign rd_hit[2] = reg_rd_en && (reg_addr == ADDR_ALERT_FLAGS_3);
  assign rd_hit[3] = reg_rd_en && (reg_addr == ADDR_ALERT_FLAGS_4);

  // Ideality code registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      diode2_ideality_reg <= RST_IDEALITY;
      diode3_ideality_reg <= RST_IDEALITY;
    end
    else if (wr_ok && reg_addr == ADDR_DIODE2_IDEALITY)
    begin
      diode2_ideality_reg <= reg_wdata[5:0];
    end
    else if (wr_ok && reg_addr == ADDR_DIODE3_IDEALITY)
    begin
      diode3_ideality_reg <= reg_wdata[5:0];
    end
  end

  // PWM configuration register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pwm_cfg_reg <= RST_PWM_CFG;
    end
    else if (wr_ok && reg_addr == ADDR_PWM_OUTPUT_CFG)
    begin
      pwm_cfg_reg <= reg_wdata[5:0];
    end
  end

  // Lock bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lock_reg <= 1'b0;
    end
    else if (wr_ok && reg_addr == ADDR_LOCK_AND_START && reg_wdata[POS_LOCK])
    begin
      lock_reg <= 1'b1;
    end
  end

  // Start status bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      start_reg <= RST_START;
    end
    else
    begin
      start_reg <= low_power_mode_bit |
                   (!power_ok_3v3_input_n && supply_power_good_input);
    end
  end

  // Alert status flags, set wins over read clear
  generate
    for (genvar r = 0; r < 4; r++)
    begin : g_alert
      assign set_now[r] = (r == 1) ?
          ((cond_level[r] & enable_in[r]) |
           ({7'h00, gpio_change_pulse & enable_in[r][POS_GPIO_CHANGE]} << POS_GPIO_CHANGE)) :
          (cond_level[r] & enable_in[r] & ((r == 3) ? ALERT4_USED : 8'hFF));
      assign read_keep[r] = (r == 1) ?
          (cond_level[r] & ~(8'h01 << POS_GPIO_CHANGE)) : cond_level[r];

      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          alert_reg[r] <= RST_ALERT;
        end
        else if (rd_hit[r])
        begin
          alert_reg[r] <= (alert_reg[r] & read_keep[r]) | set_now[r];
        end
        else
        begin
          alert_reg[r] <= alert_reg[r] | set_now[r];
        end
      end
    end
  endgenerate

  assign any_flag = |{alert_reg[0], alert_reg[1], alert_reg[2], alert_reg[3]};

  // Interrupt pin
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      alert_interrupt_pin_n <= 1'b1;
    end
    else
    begin
      alert_interrupt_pin_n <= !(any_flag && global_interrupt_enable);
    end
  end

  // Read data multiplexer
  always_comb
  begin
    case (reg_addr)
      ADDR_DIODE2_IDEALITY: rdata_next = {2'b00, diode2_ideality_reg};
      ADDR_DIODE3_IDEALITY: rdata_next = {2'b00, diode3_ideality_reg};
      ADDR_PWM_OUTPUT_CFG:  rdata_next = {2'b00, pwm_cfg_reg};
      ADDR_MAKER_CODE:      rdata_next = MAKER_CODE_VALUE;
      ADDR_DIE_REVISION:    rdata_next = DIE_REVISION_VALUE;
      ADDR_LOCK_AND_START:  rdata_next = {6'h00, lock_reg, start_reg};
      ADDR_ALERT_FLAGS_1:   rdata_next = alert_reg[0];
      ADDR_ALERT_FLAGS_2:   rdata_next = alert_reg[1];
      ADDR_ALERT_FLAGS_3:   rdata_next = alert_reg[2];
      ADDR_ALERT_FLAGS_4:   rdata_next = alert_reg[3];
      default:              rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd_en)
    begin
      reg_rdata <= rdata_next;
    end
  end

  // Ideality code to factor, clamped to the table range
  function automatic logic [13:0] fmcsb_factor(input logic [5:0] code);
    logic [5:0]  c;
    logic [13:0] steps;
    logic [19:0] scaled;
    c = (code < IDEAL_CODE_MIN) ? IDEAL_CODE_MIN :
        (code > IDEAL_CODE_MAX) ? IDEAL_CODE_MAX : code;
    steps  = {8'h00, c - IDEAL_CODE_MIN};
    scaled = ({6'h00, steps} * {6'h00, IDEAL_STEP_E2}) / {6'h00, IDEAL_STEP_DIV};
    return IDEAL_FACTOR_MIN + scaled[13:0];
  endfunction : fmcsb_factor

  // Configuration outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      diode2_ideality_code   <= RST_IDEALITY;
      diode3_ideality_code   <= RST_IDEALITY;
      diode2_factor_e4       <= 14'h0000;
      diode3_factor_e4       <= 14'h0000;
      first_pwm_output_type  <= RST_PWM_CFG[POS_FIRST_PWM_TYPE];
      second_pwm_output_type <= RST_PWM_CFG[POS_SECOND_PWM_TYPE];
      first_pwm_freq_select  <= RST_PWM_CFG[POS_FIRST_FREQ +: 2];
      second_pwm_freq_select <= RST_PWM_CFG[POS_SECOND_FREQ +: 2];
      software_lock          <= 1'b0;
      start_status           <= RST_START;
    end
    else
    begin
      diode2_ideality_code   <= diode2_ideality_reg;
      diode3_ideality_code   <= diode3_ideality_reg;
      diode2_factor_e4       <= fmcsb_factor(diode2_ideality_reg);
      diode3_factor_e4       <= fmcsb_factor(diode3_ideality_reg);
      first_pwm_output_type  <= pwm_cfg_reg[POS_FIRST_PWM_TYPE];
      second_pwm_output_type <= pwm_cfg_reg[POS_SECOND_PWM_TYPE];
      first_pwm_freq_select  <= pwm_cfg_reg[POS_FIRST_FREQ +: 2];
      second_pwm_freq_select <= pwm_cfg_reg[POS_SECOND_FREQ +: 2];
      software_lock          <= lock_reg;
      start_status           <= start_reg;
    end
  end

  // PWM generators, one per fan
  logic [1:0] pin_out;
  logic [1:0] pin_oe;

  generate
    for (genvar f = 0; f < 2; f++)
    begin : g_pwm
      logic [1:0] sel;
      logic       push_pull;
      logic [9:0] duty;
      logic [4:0] div_cnt_reg;
      logic [4:0] div_top;
      logic [9:0] step_reg;
      logic [9:0] step_top;
      logic [9:0] duty_eff;
      logic       level;

      assign sel = (f == 1) ? pwm_cfg_reg[POS_SECOND_FREQ +: 2] :
                              pwm_cfg_reg[POS_FIRST_FREQ +: 2];
      assign push_pull = (f == 1) ? pwm_cfg_reg[POS_SECOND_PWM_TYPE] :
                                    pwm_cfg_reg[POS_FIRST_PWM_TYPE];
      assign duty = (f == 1) ? fan2_duty : fan1_duty;

      always_comb
      begin
        case (sel)
          FREQ_26K:  div_top = DIV_26K;
          FREQ_19K5: div_top = DIV_19K5;
          FREQ_4882: div_top = DIV_4882;
          FREQ_2441: div_top = DIV_2441;
          default:   div_top = DIV_2441;
        endcase
      end

      assign step_top = (sel == FREQ_26K) ? TOP_8BIT : TOP_10BIT;
      assign duty_eff = (sel == FREQ_26K) ? {2'b00, duty[9:2]} : duty;
      assign level    = (step_reg < duty_eff);

      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          div_cnt_reg <= 5'h00;
          step_reg    <= 10'h000;
        end
        else if (div_cnt_reg >= div_top - 5'd1)
        begin
          div_cnt_reg <= 5'h00;
          step_reg    <= (step_reg >= step_top) ? 10'h000 : step_reg + 10'd1;
        end
        else
        begin
          div_cnt_reg <= div_cnt_reg + 5'd1;
        end
      end

      // Open drain drives low only; push-pull always drives
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          pin_out[f] <= 1'b0;
          pin_oe[f]  <= 1'b0;
        end
        else
        begin
          pin_out[f] <= push_pull & level;
          pin_oe[f]  <= push_pull | !level;
        end
      end
    end
  endgenerate

  assign first_pwm_pin_out  = pin_out[0];
  assign first_pwm_pin_oe   = pin_oe[0];
  assign second_pwm_pin_out = pin_out[1];
  assign second_pwm_pin_oe  = pin_oe[1];

endmodule : fmcsb_bank

// >>> fmcsb_monitor.sv
// Checker of timing relations at the register bank ports
`timescale 1ns/100ps
module fmcsb_monitor
  import fmcsb_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE_VALUE   = 8'hA7,
  parameter logic [7:0] DIE_REVISION_VALUE = 8'h01
)
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_power_mode_bit,
  input wire logic       power_ok_3v3_input_n,
  input wire logic       supply_power_good_input,
  input wire logic       global_interrupt_enable,
  input wire logic [7:0] alert_enable_1,
  input wire logic [7:0] alert_cond_1,
  input wire logic       alert_interrupt_pin_n,
  input wire logic       first_pwm_output_type,
  input wire logic       second_pwm_output_type,
  input wire logic [1:0] first_pwm_freq_select,
  input wire logic [1:0] second_pwm_freq_select,
  input wire logic       first_pwm_pin_out,
  input wire logic       software_lock,
  input wire logic       start_status
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_lock_sticky: assert property (software_lock |=> software_lock)
    else $error("lock bit dropped");
  a_start_lpm: assert property (low_power_mode_bit |=> ##1 start_status)
    else $error("start clear in low power");
  a_start_off: assert property (!low_power_mode_bit &&
    (power_ok_3v3_input_n || !supply_power_good_input) |=> ##1 !start_status)
    else $error("start set without power good");
  a_start_on: assert property (!low_power_mode_bit &&
    !power_ok_3v3_input_n && supply_power_good_input |=> ##1 start_status)
    else $error("start clear with power good");
  a_pin_gated: assert property (!global_interrupt_enable |=> alert_interrupt_pin_n)
    else $error("pin low while disabled");
  a_flag_pin: assert property (alert_enable_1[0] && alert_cond_1[0]
    ##1 global_interrupt_enable |=> !alert_interrupt_pin_n)
    else $error("pin not low after flag");
  a_lock_write: assert property (software_lock && reg_wr_en &&
    reg_addr == ADDR_PWM_OUTPUT_CFG && !$past(reg_wr_en) |=> ##1 $stable({second_pwm_output_type,
    first_pwm_output_type, second_pwm_freq_select, first_pwm_freq_select}))
    else $error("locked config changed");
  a_maker_read: assert property (reg_rd_en && reg_addr == ADDR_MAKER_CODE
    |=> reg_rdata == MAKER_CODE_VALUE)
    else $error("maker code wrong");
  a_rev_read: assert property (reg_rd_en && reg_addr == ADDR_DIE_REVISION
    |=> reg_rdata == DIE_REVISION_VALUE)
    else $error("revision wrong");
  a_open_drain: assert property (!first_pwm_output_type &&
    !$past(first_pwm_output_type) |-> !first_pwm_pin_out)
    else $error("open drain pin driven high");
endmodule : fmcsb_monitor

// >>> fmcsb_host.sv
// Host model issuing register reads and writes
`timescale 1ns/100ps
module fmcsb_host (
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : fmcsb_host

// >>> fmcsb_bank_test.sv
// Self-checking bench for the configuration and status bank
`timescale 1ns/100ps
module fmcsb_bank_test
  import fmcsb_pkg::*;
;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] RV = 8'h03;
  localparam logic [7:0] RA [11] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41,
                                     8'h42, 8'h44, 8'h45, 8'h43};
  localparam logic [7:0] RD [11] = '{8'h12, 8'h12, 8'h0F, MK, RV, 8'h01, 8'h00,
                                     8'h00, 8'h00, 8'h00, 8'h00};
  logic core_clk, rst_n, reg_wr_en, reg_rd_en, low_power_mode_bit, power_ok_3v3_input_n;
  logic supply_power_good_input, global_interrupt_enable, gpio_change_pulse, fan1_stall;
  logic fan1_spinup_fail, fan1_drive_fail, fan2_stall, fan2_spinup_fail, fan2_drive_fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, alert_enable_1, alert_enable_2, v;
  logic [7:0] alert_enable_3, alert_enable_4, alert_cond_1, alert_cond_3;
  logic [6:0] alert_cond_2;
  logic [4:0] alert_cond_4;
  logic [9:0] fan1_duty, fan2_duty;
  logic [13:0] diode2_factor_e4, diode3_factor_e4;
  logic [5:0] diode2_ideality_code, diode3_ideality_code;
  logic [1:0] first_pwm_freq_select, second_pwm_freq_select;
  logic alert_interrupt_pin_n, first_pwm_output_type, second_pwm_output_type, software_lock;
  logic first_pwm_pin_out, first_pwm_pin_oe, second_pwm_pin_out, second_pwm_pin_oe, start_status;
  int fail_count, comparisons;

  fmcsb_bank #(.MAKER_CODE_VALUE(MK), .DIE_REVISION_VALUE(RV)) DUT (.*);
  fmcsb_host host (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(14'(v), 14'(e));
  endtask : rd_chk

  task automatic pwm_count(input logic [7:0] cfg, input int span, input logic [13:0] e1,
                           input logic [13:0] e2);
    logic [13:0] n1;
    logic [13:0] n2;
    n1 = 14'h0000;
    n2 = 14'h0000;
    host.wr(8'h3D, cfg);
    repeat (64) @(negedge core_clk);
    // Pin seen through a pull-up: released reads high
    repeat (span)
    begin
      @(negedge core_clk);
      n1 += 14'(first_pwm_pin_oe ? first_pwm_pin_out : 1'b1);
      n2 += 14'(second_pwm_pin_oe ? second_pwm_pin_out : 1'b1);
    end
    chk(n1, e1);
    chk(n2, e2);
  endtask : pwm_count

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    {rst_n, low_power_mode_bit, power_ok_3v3_input_n, gpio_change_pulse} = 4'h0;
    {fan1_stall, fan1_spinup_fail, fan1_drive_fail, fan2_stall} = 4'h0;
    {fan2_spinup_fail, fan2_drive_fail} = 2'b00;
    supply_power_good_input = 1'b1;
    global_interrupt_enable = 1'b1;
    {alert_enable_1, alert_enable_2, alert_enable_3, alert_enable_4} = 32'hFFFF_FFFF;
    {alert_cond_1, alert_cond_2, alert_cond_3, alert_cond_4} = 28'h000_0000;
    fan1_duty = 10'h080;
    fan2_duty = 10'h200;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 11; i++)
      rd_chk(RA[i], RD[i]);
    $display("reset values done");
    pwm_count(8'h30, 1792, 14'h00E0, 14'h0380);
    pwm_count(8'h05, 2048, 14'h0100, 14'h0400);
    $display("pwm duty done");
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h3D, 8'h30 | 8'(k * 5));
      repeat (2) @(negedge core_clk);
      chk(14'(second_pwm_freq_select), 14'(k));
      chk(14'(first_pwm_freq_select), 14'(k));
      chk(14'({second_pwm_output_type, first_pwm_output_type}), 14'h0003);
    end
    host.wr(8'h3B, 8'h08);
    host.wr(8'h3C, 8'h37);
    repeat (3) @(negedge core_clk);
    chk(diode2_factor_e4, 14'h26DF);
    chk(diode3_factor_e4, 14'h295D);
    chk(14'(diode2_ideality_code), 14'h0008);
    chk(14'(diode3_ideality_code), 14'h0037);
    rd_chk(8'h3C, 8'h37);
    $display("config done");
    alert_cond_1 = 8'h81;
    @(negedge core_clk);
    alert_cond_1 = 8'h01;
    repeat (2) @(negedge core_clk);
    chk(14'(alert_interrupt_pin_n), 14'h0000);
    rd_chk(8'h41, 8'h81);
    rd_chk(8'h41, 8'h01);
    alert_cond_1 = 8'h00;
    rd_chk(8'h41, 8'h01);
    rd_chk(8'h41, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(14'(alert_interrupt_pin_n), 14'h0001);
    global_interrupt_enable = 1'b0;
    alert_enable_1 = 8'hEF;
    alert_cond_1 = 8'h30;
    repeat (3) @(negedge core_clk);
    chk(14'(alert_interrupt_pin_n), 14'h0001);
    alert_cond_1 = 8'h00;
    rd_chk(8'h41, 8'h20);
    rd_chk(8'h41, 8'h00);
    global_interrupt_enable = 1'b1;
    alert_enable_1 = 8'hDF;
    alert_cond_2 = 7'h7F;
    gpio_change_pulse = 1'b1;
    @(negedge core_clk);
    gpio_change_pulse = 1'b0;
    rd_chk(8'h42, 8'hFF);
    alert_cond_2 = 7'h00;
    rd_chk(8'h42, 8'h7F);
    rd_chk(8'h42, 8'h00);
    alert_cond_3 = 8'hA5;
    {fan1_drive_fail, fan2_spinup_fail, alert_cond_4} = 7'h7F;
    @(negedge core_clk);
    {fan1_drive_fail, fan2_spinup_fail, alert_cond_4} = 7'h00;
    alert_cond_3 = 8'h00;
    rd_chk(8'h44, 8'hA5);
    rd_chk(8'h45, 8'hDF);
    rd_chk(8'h45, 8'h00);
    $display("alert flags done");
    power_ok_3v3_input_n = 1'b1;
    rd_chk(8'h40, 8'h00);
    low_power_mode_bit = 1'b1;
    rd_chk(8'h40, 8'h01);
    {low_power_mode_bit, power_ok_3v3_input_n, supply_power_good_input} = 3'b000;
    rd_chk(8'h40, 8'h00);
    supply_power_good_input = 1'b1;
    rd_chk(8'h40, 8'h01);
    $display("start status done");
    host.wr(8'h40, 8'h02);
    rd_chk(8'h40, 8'h03);
    host.wr(8'h3D, 8'h00);
    host.wr(8'h3B, 8'h20);
    host.wr(8'h40, 8'h00);
    host.wr(8'h3E, 8'h00);
    rd_chk(8'h3D, 8'h3F);
    rd_chk(8'h3B, 8'h08);
    rd_chk(8'h40, 8'h03);
    rd_chk(8'h3E, MK);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    rd_chk(8'h40, 8'h01);
    rd_chk(8'h3B, 8'h12);
    $display("lock done");
    close_out();
  end
endmodule : fmcsb_bank_test

bind fmcsb_bank fmcsb_monitor #(
  .MAKER_CODE_VALUE  (MAKER_CODE_VALUE),
  .DIE_REVISION_VALUE(DIE_REVISION_VALUE)
) mon (.core_clk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_rdata,
  .low_power_mode_bit, .power_ok_3v3_input_n, .supply_power_good_input,
  .global_interrupt_enable, .alert_enable_1, .alert_cond_1, .alert_interrupt_pin_n,
  .first_pwm_output_type, .second_pwm_output_type, .first_pwm_freq_select,
  .second_pwm_freq_select, .first_pwm_pin_out, .software_lock, .start_status);
